// file: core/vdo_pkg.sv
package vdo_pkg;

  // Word timing of the embedded-sync stream
  localparam int unsigned WORD_PERIOD_NS = 37;
  localparam int unsigned WORD_RATE_MHZ  = 27;
  localparam int unsigned SYS_CLK_MHZ    = 125;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CLAMP  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_HCOUNT = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_FMT_LSB  = 0;
  localparam int unsigned CTRL_SMP_LSB  = 2;
  localparam int unsigned CTRL_VOVR_BIT = 5;
  localparam int unsigned CTRL_CLMP_BIT = 6;
  localparam int unsigned CTRL_FM2_BIT  = 7;
  localparam int unsigned CTRL_SR_BIT   = 8;
  localparam logic [15:0] CTRL_RESET    = 16'h0001;
  localparam logic [15:0] CLAMP_RESET   = 16'h1000;

  typedef enum logic [1:0] {
    FMT_EMBED = 2'h0,
    FMT_MUX8  = 2'h1,
    FMT_YC16  = 2'h2,
    FMT_RGB24 = 2'h3
  } out_fmt_t;

  // Sampling modes
  localparam logic [2:0] SMP_525_601  = 3'h0;
  localparam logic [2:0] SMP_525_SQ   = 3'h1;
  localparam logic [2:0] SMP_525_4FSC = 3'h2;
  localparam logic [2:0] SMP_625_601  = 3'h4;
  localparam logic [2:0] SMP_625_SQ   = 3'h5;

  // Pixels per line: total, active, front porch
  localparam logic [10:0] TOT_525_601  = 11'd858;
  localparam logic [10:0] ACT_525_601  = 11'd720;
  localparam logic [10:0] FP_525_601   = 11'd16;
  localparam logic [10:0] TOT_525_SQ   = 11'd780;
  localparam logic [10:0] ACT_525_SQ   = 11'd640;
  localparam logic [10:0] FP_525_SQ    = 11'd28;
  localparam logic [10:0] TOT_525_4FSC = 11'd910;
  localparam logic [10:0] ACT_525_4FSC = 11'd768;
  localparam logic [10:0] FP_525_4FSC  = 11'd8;
  localparam logic [10:0] TOT_625_601  = 11'd864;
  localparam logic [10:0] ACT_625_601  = 11'd720;
  localparam logic [10:0] FP_625_601   = 11'd12;
  localparam logic [10:0] TOT_625_SQ   = 11'd944;
  localparam logic [10:0] ACT_625_SQ   = 11'd768;
  localparam logic [10:0] FP_625_SQ    = 11'd34;

  // Timing reference words and blanking levels
  localparam logic [10:0] TRS_LEN   = 11'd4;
  localparam logic [7:0]  TRS_ONES  = 8'hFF;
  localparam logic [7:0]  TRS_ZERO  = 8'h00;
  localparam logic [7:0]  BLANK_Y   = 8'h10;
  localparam logic [7:0]  BLANK_C   = 8'h80;
  localparam logic [23:0] BLANK_RGB = 24'h10_1010;

endpackage : vdo_pkg

// file: core/sync2.sv
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : sync2

`default_nettype wire

// file: core/video_decoder_output_timing.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

module video_decoder_output_timing #(
  parameter int unsigned HSYNC_PIX = 64
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  pix_clk_in,
  input  wire logic                  mode_pin0_in,
  input  wire logic                  line_restart,
  input  wire logic [7:0]            y_in,
  input  wire logic [7:0]            cb_in,
  input  wire logic [7:0]            cr_in,
  input  wire logic [23:0]           rgb_in,
  input  wire logic                  field_in,
  input  wire logic                  vblank_in,
  input  wire logic                  vsync_in,
  input  wire logic                  vertical_valid,
  input  wire logic [3:0]            vbi_flags_in,
  output logic      [23:0]           video_out,
  output logic                       hsync_n,
  output logic                       vsync_n,
  output logic                       double_rate_clock_out,
  output logic                       clamp_timing_pulse,
  output logic                       vbi_detect_pin,
  output logic                       fm_write_pointer_reset,
  output logic                       fm_read_pointer_reset,
  output logic                       fm_write_enable,
  output logic                       fm_read_strobe,
  output logic                       fm_ctrl_oe,
  output vdo_pkg::out_fmt_t          output_format_select
);

  import vdo_pkg::*;

  typedef struct packed {
    out_fmt_t    fmt;
    logic [2:0]  smp;
    logic        vovr;
    logic        clamp_en;
    logic        fm2;
    logic        single_rate;
    logic [7:0]  clamp_start;
    logic [7:0]  clamp_end;
    logic [10:0] hcnt;
    logic        pclk_prev;
    logic        div;
    logic [7:0]  cr_hold;
    logic [15:0] rdata;
    logic [23:0] video;
    logic        hsync_n;
    logic        vsync_n;
    logic        clk_out;
    logic        clamp_pulse;
    logic        vbi_pin;
    logic [3:0]  fm_ctrl;
    logic        fm_oe;
    logic        vval_prev;
    logic        vs_prev;
  } state_t;

  localparam state_t RESET_STATE = '{
    fmt:         out_fmt_t'(CTRL_RESET[CTRL_FMT_LSB +: 2]),
    smp:         CTRL_RESET[CTRL_SMP_LSB +: 3],
    vovr:        CTRL_RESET[CTRL_VOVR_BIT],
    clamp_en:    CTRL_RESET[CTRL_CLMP_BIT],
    fm2:         CTRL_RESET[CTRL_FM2_BIT],
    single_rate: CTRL_RESET[CTRL_SR_BIT],
    clamp_start: CLAMP_RESET[7:0],
    clamp_end:   CLAMP_RESET[15:8],
    hsync_n:     1'b1,
    vsync_n:     1'b1,
    default:     '0
  };

  state_t      s_ff;
  state_t      nxt_s;
  logic [1:0]  pin_q;

  sync2 #(
    .W (2)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({mode_pin0_in, pix_clk_in}),
    .q       (pin_q)
  );

  function automatic logic [7:0] status_word(input logic f, input logic v, input logic h);
    // Protection bits as parity of flag pairs, last bit parity of all three flags
    status_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : status_word

  always_comb
  begin
    logic [10:0] tot;
    logic [10:0] act;
    logic [10:0] fp;
    logic [10:0] blank_u;
    logic [10:0] len_u;
    logic [10:0] pix;
    logic        wide;
    logic        tick;
    logic        step;
    logic        in_act;
    logic        vflag;
    logic        pic;
    logic [7:0]  word8;
    logic [7:0]  blank8;
    logic [1:0]  trs_idx;
    logic        trs_h;
    logic        in_trs;
    tot     = TOT_525_601;
    act     = ACT_525_601;
    fp      = FP_525_601;
    blank_u = '0;
    len_u   = '0;
    pix     = '0;
    wide    = 1'b0;
    tick    = 1'b0;
    step    = 1'b0;
    in_act  = 1'b0;
    vflag   = 1'b0;
    pic     = 1'b0;
    word8   = '0;
    blank8  = '0;
    trs_idx = '0;
    trs_h   = 1'b0;
    in_trs  = 1'b0;
    nxt_s   = s_ff;

    case (s_ff.smp)
      SMP_525_SQ:
      begin
        tot = TOT_525_SQ;
        act = ACT_525_SQ;
        fp  = FP_525_SQ;
      end
      SMP_525_4FSC:
      begin
        tot = TOT_525_4FSC;
        act = ACT_525_4FSC;
        fp  = FP_525_4FSC;
      end
      SMP_625_601:
      begin
        tot = TOT_625_601;
        act = ACT_625_601;
        fp  = FP_625_601;
      end
      SMP_625_SQ:
      begin
        tot = TOT_625_SQ;
        act = ACT_625_SQ;
        fp  = FP_625_SQ;
      end
      default:
      begin
        tot = TOT_525_601;
        act = ACT_525_601;
        fp  = FP_525_601;
      end
    endcase

    // Wide formats count pixels, 8-bit formats count words
    wide    = s_ff.fmt[1];
    blank_u = wide ? 11'(tot - act) : 11'((tot - act) << 1);
    len_u   = wide ? tot : 11'(tot << 1);
    pix     = wide ? s_ff.hcnt : 11'(s_ff.hcnt >> 1);

    // Each rising edge of the sampled word clock is one word slot
    tick            = pin_q[0] & ~s_ff.pclk_prev;
    nxt_s.pclk_prev = pin_q[0];
    if (tick && wide && !s_ff.single_rate)
    begin
      nxt_s.div = ~s_ff.div;
    end
    step = tick & (~wide | s_ff.single_rate | s_ff.div);

    // Output clock follows the word rate of the chosen format
    if (wide && !s_ff.single_rate)
    begin
      nxt_s.clk_out = s_ff.div;
    end
    else
    begin
      nxt_s.clk_out = pin_q[0];
    end

    in_act  = s_ff.hcnt >= blank_u;
    vflag   = vblank_in & ~(s_ff.vovr & (|vbi_flags_in));
    pic     = in_act & ~vblank_in;
    blank8  = s_ff.hcnt[0] ? BLANK_Y : BLANK_C;
    in_trs  = 1'b0;
    trs_h   = 1'b0;
    trs_idx = s_ff.hcnt[1:0];
    if (s_ff.hcnt < TRS_LEN)
    begin
      in_trs = 1'b1;
      trs_h  = 1'b1;
    end
    else if (s_ff.hcnt >= 11'(blank_u - TRS_LEN) && !in_act)
    begin
      in_trs = 1'b1;
    end

    // Active multiplexed words; blanking length keeps phase 0 on Cb
    case (s_ff.hcnt[1:0])
      2'd0:    word8 = cb_in;
      2'd2:    word8 = s_ff.cr_hold;
      default: word8 = y_in;
    endcase

    if (step)
    begin
      if (s_ff.hcnt[1:0] == 2'd0)
      begin
        nxt_s.cr_hold = cr_in;
      end
      if (s_ff.hcnt >= 11'(len_u - 11'd1))
      begin
        nxt_s.hcnt = '0;
      end
      else
      begin
        nxt_s.hcnt = 11'(s_ff.hcnt + 11'd1);
      end

      case (s_ff.fmt)
        FMT_EMBED:
        begin
          if (in_trs)
          begin
            case (trs_idx)
              2'd0:    nxt_s.video = {16'h0000, TRS_ONES};
              2'd3:    nxt_s.video = {16'h0000, status_word(field_in, vflag, trs_h)};
              default: nxt_s.video = {16'h0000, TRS_ZERO};
            endcase
          end
          else
          begin
            nxt_s.video = {16'h0000, pic ? word8 : blank8};
          end
        end
        FMT_MUX8:
        begin
          nxt_s.video = {16'h0000, pic ? word8 : blank8};
        end
        FMT_YC16:
        begin
          if (pic)
          begin
            nxt_s.video = {8'h00, pix[0] ? cr_in : cb_in, y_in};
          end
          else
          begin
            nxt_s.video = {8'h00, BLANK_C, BLANK_Y};
          end
        end
        default:
        begin
          nxt_s.video = pic ? rgb_in : BLANK_RGB;
        end
      endcase

      nxt_s.hsync_n = ~(pix >= fp && pix < 11'(fp + 11'(HSYNC_PIX)));
      // Clamp edges are offsets from the start of sync toward the pedestal
      nxt_s.clamp_pulse = s_ff.clamp_en &&
                          pix >= 11'(fp + 11'(s_ff.clamp_start)) &&
                          pix <  11'(fp + 11'(s_ff.clamp_end));
      nxt_s.fm_ctrl[2] = in_act & vertical_valid & ~vblank_in;
      nxt_s.fm_ctrl[3] = in_act & vertical_valid;
    end

    // Restart from the decoder's line reference; length is not held exactly
    if (line_restart)
    begin
      nxt_s.hcnt = '0;
    end

    nxt_s.vsync_n   = ~vsync_in;
    nxt_s.vbi_pin   = |vbi_flags_in;
    nxt_s.vs_prev   = vsync_in;
    nxt_s.vval_prev = vertical_valid;
    // Pointer resets are one-cycle pulses at field and valid-region starts
    nxt_s.fm_ctrl[0] = vsync_in & ~s_ff.vs_prev;
    nxt_s.fm_ctrl[1] = vertical_valid & ~s_ff.vval_prev;
    // Pins are only driven when the board strap confirms memory mode
    nxt_s.fm_oe = s_ff.fm2 & pin_q[1];

    nxt_s.rdata = 16'h0000;
    if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        nxt_s.fmt         = out_fmt_t'(reg_wdata[CTRL_FMT_LSB +: 2]);
        nxt_s.smp         = reg_wdata[CTRL_SMP_LSB +: 3];
        nxt_s.vovr        = reg_wdata[CTRL_VOVR_BIT];
        nxt_s.clamp_en    = reg_wdata[CTRL_CLMP_BIT];
        nxt_s.fm2         = reg_wdata[CTRL_FM2_BIT];
        nxt_s.single_rate = reg_wdata[CTRL_SR_BIT];
      end
      else if (reg_addr == ADDR_CLAMP)
      begin
        nxt_s.clamp_start = reg_wdata[7:0];
        nxt_s.clamp_end   = reg_wdata[15:8];
      end
    end
    if (reg_rd)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        nxt_s.rdata = {7'h00, s_ff.single_rate, s_ff.fm2, s_ff.clamp_en,
                       s_ff.vovr, s_ff.smp, s_ff.fmt};
      end
      else if (reg_addr == ADDR_CLAMP)
      begin
        nxt_s.rdata = {s_ff.clamp_end, s_ff.clamp_start};
      end
      else if (reg_addr == ADDR_STATUS)
      begin
        nxt_s.rdata = {8'h00, s_ff.fm_oe, vertical_valid, vblank_in, field_in,
                       vbi_flags_in};
      end
      else if (reg_addr == ADDR_HCOUNT)
      begin
        nxt_s.rdata = {5'h00, s_ff.hcnt};
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_ff <= RESET_STATE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata              = s_ff.rdata;
  assign video_out              = s_ff.video;
  assign hsync_n                = s_ff.hsync_n;
  assign vsync_n                = s_ff.vsync_n;
  assign double_rate_clock_out  = s_ff.clk_out;
  assign clamp_timing_pulse     = s_ff.clamp_pulse;
  assign vbi_detect_pin         = s_ff.vbi_pin;
  assign fm_write_pointer_reset = s_ff.fm_ctrl[0] & s_ff.fm_oe;
  assign fm_read_pointer_reset  = s_ff.fm_ctrl[1] & s_ff.fm_oe;
  assign fm_write_enable        = s_ff.fm_ctrl[2] & s_ff.fm_oe;
  assign fm_read_strobe         = s_ff.fm_ctrl[3] & s_ff.fm_oe;
  assign fm_ctrl_oe             = s_ff.fm_oe;
  assign output_format_select   = s_ff.fmt;

endmodule : video_decoder_output_timing

`default_nettype wire

// file: verif/vdo_checker.sv
`timescale 1ns/100ps
`default_nettype none
module vdo_checker #(
  parameter int unsigned HSYNC_PIX = 64
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              mode_pin0_in,
  input wire logic              vsync_in,
  input wire logic              vsync_n,
  input wire logic [3:0]        vbi_flags_in,
  input wire logic [23:0]       video_out,
  input wire logic              clamp_timing_pulse,
  input wire logic              vbi_detect_pin,
  input wire logic              fm_write_pointer_reset,
  input wire logic              fm_read_pointer_reset,
  input wire logic              fm_write_enable,
  input wire logic              fm_read_strobe,
  input wire logic              fm_ctrl_oe,
  input wire vdo_pkg::out_fmt_t output_format_select
);
  import vdo_pkg::*;
  logic [15:0] ctrl_sh;
  // Shadow of the control word, so modes can be judged without the body
  always_ff @(posedge sys_clk)
    if (rst)
      ctrl_sh <= CTRL_RESET;
    else if (reg_wr && reg_addr == ADDR_CTRL)
      ctrl_sh <= reg_wdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence pin_low3;
    !mode_pin0_in [*3];
  endsequence
  sequence pin_high3;
    mode_pin0_in [*3];
  endsequence
  fmt_follow_a: assert property (
    reg_wr && reg_addr == ADDR_CTRL |=> output_format_select == $past(reg_wdata[1:0]))
    else $error("format select missed a control write");
  upper_zero_a: assert property (
    output_format_select inside {FMT_EMBED, FMT_MUX8} && $stable(output_format_select)
    && $changed(video_out) |-> video_out[23:8] == 16'h0000)
    else $error("upper video bits set in an 8-bit format");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside the read answer cycle");
  vbi_pin_a: assert property (1'b1 |=> vbi_detect_pin == |$past(vbi_flags_in))
    else $error("detect pin does not follow the flags");
  vsync_follow_a: assert property (1'b1 |=> vsync_n == !$past(vsync_in))
    else $error("vertical sync output does not follow its input");
  fm_gate_a: assert property (
    !fm_ctrl_oe |-> !(fm_write_pointer_reset || fm_read_pointer_reset
    || fm_write_enable || fm_read_strobe))
    else $error("memory pin active while not driven");
  fm_pulse_a: assert property (fm_write_pointer_reset |=> !fm_write_pointer_reset)
    else $error("write pointer reset longer than one cycle");
  fm_oe_off_a: assert property (pin_low3 |=> !fm_ctrl_oe)
    else $error("memory pins driven with mode pin low");
  fm_oe_on_a: assert property (
    pin_high3 ##0 ctrl_sh[CTRL_FM2_BIT] |=> fm_ctrl_oe)
    else $error("memory pins not driven in memory mode");
  clamp_off_a: assert property (
    !ctrl_sh[CTRL_CLMP_BIT] && !$past(ctrl_sh[CTRL_CLMP_BIT]) |-> !clamp_timing_pulse)
    else $error("clamp pulse while clamping is off");
endmodule : vdo_checker
bind video_decoder_output_timing vdo_checker #(.HSYNC_PIX(HSYNC_PIX)) chk (.*);
`default_nettype wire

// file: verif/vdo_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module vdo_far_end (
  input  wire logic strap_en,
  output logic      pix_clk,
  output logic      mode_pin0
);
  // Source word clock runs free, as a pixel clock does
  initial
  begin
    pix_clk = 1'b0;
    #37;
    forever #80 pix_clk = ~pix_clk;
  end
  assign mode_pin0 = strap_en;
endmodule : vdo_far_end
`default_nettype wire

// file: verif/video_decoder_output_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module video_decoder_output_timing_tb;
  import vdo_pkg::*;
  logic        sys_clk, rst, reg_wr, reg_rd, line_restart, strap_en, pix_clk_in;
  logic        field_in, vblank_in, vsync_in, vertical_valid, mode_pin0_in;
  logic [3:0]  reg_addr, vbi_flags_in;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [7:0]  y_in, cb_in, cr_in, w;
  logic [23:0] rgb_in, video_out;
  logic [15:0] rq[$];
  logic [7:0]  sq[$];
  logic [3:0]  prot[8] = '{4'h0, 4'hD, 4'hB, 4'h6, 4'h7, 4'hA, 4'hC, 4'h1};
  logic [2:0]  smp[5] = '{SMP_525_601, SMP_525_SQ, SMP_525_4FSC, SMP_625_601, SMP_625_SQ};
  int          failures, comparisons, seed, nst, n;
  int          k = 1000;
  bit          en_mon, len_ok, act, rd_d;

  video_decoder_output_timing #(.HSYNC_PIX(8)) uut (
    .*, .hsync_n(), .vsync_n(), .double_rate_clock_out(), .clamp_timing_pulse(),
    .vbi_detect_pin(), .fm_write_pointer_reset(), .fm_read_pointer_reset(),
    .fm_write_enable(), .fm_read_strobe(), .fm_ctrl_oe(), .output_format_select()
  );
  vdo_far_end far (.strap_en(strap_en), .pix_clk(pix_clk_in), .mode_pin0(mode_pin0_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task results;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task miss(input logic [23:0] g, e);
    failures++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask : miss
  task chk_reg(input logic [15:0] g, e);
    comparisons++;
    if (g !== e)
      miss(24'(g), 24'(e));
  endtask : chk_reg
  task chk_vid(input logic [23:0] g, e);
    comparisons++;
    if (g !== e)
      miss(g, e);
  endtask : chk_vid

  task wr(input logic [3:0] a, input logic [15:0] dd);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= dd;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task restart;
    @(posedge sys_clk);
    line_restart <= 1'b1;
    len_ok = 1'b0;
    @(posedge sys_clk);
    line_restart <= 1'b0;
  endtask : restart
  // Expects one end code then one start code with the given field and blanking flags
  task line(input logic f, vb, v, input bit rs, input int lim);
    int t;
    int c;
    t = nst + 2;
    c = 0;
    field_in <= f;
    vblank_in <= vb;
    sq.push_back({1'b1, f, v, 1'b1, prot[{f, v, 1'b1}]});
    sq.push_back({1'b1, f, v, 1'b0, prot[{f, v, 1'b0}]});
    if (rs)
      restart;
    while (nst < t && c < lim)
    begin
      @(posedge sys_clk);
      c++;
    end
    chk_vid(24'(nst), 24'(t));
    repeat (200) @(posedge sys_clk);
  endtask : line

  function automatic logic [7:0] exp_word(input int i);
    if (act && !vblank_in)
      return (i % 2) ? y_in : ((i % 4) == 0 ? cb_in : cr_in);
    return (i % 2) ? BLANK_Y : BLANK_C;
  endfunction : exp_word

  always @(posedge sys_clk)
  begin
    if (rd_d)
      chk_reg(reg_rdata, rq.pop_front());
    rd_d <= reg_rd;
  end

  // Mid-word sampling keeps clear of the synchroniser delay on each word
  always @(negedge pix_clk_in)
    if (en_mon)
    begin
      w = video_out[7:0];
      n++;
      k++;
      if (w === TRS_ONES)
        k = 0;
      else if (k < 3)
        chk_vid(24'(w), 24'h00_0000);
      else if (k == 3)
      begin
        chk_vid(24'(w), 24'(sq.pop_front()));
        if (w[4] && len_ok)
          chk_vid(24'(n - 3), 24'(2 * TOT_525_601));
        n = w[4] ? 3 : n;
        len_ok |= w[4];
        act = !w[4];
        nst++;
      end
      else if (k < 8 || (!act && k < 272))
        chk_vid(24'(w), 24'(exp_word(k)));
    end

  initial
  begin
    repeat (95000) @(posedge sys_clk);
    failures++;
    results;
  end

  initial
  begin
    seed = 99;
    {reg_wr, reg_rd, line_restart, strap_en, vsync_in, field_in, vblank_in} = '0;
    rst = 1'b1;
    vertical_valid = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    vbi_flags_in = 4'($random(seed));
    y_in = 8'h20 + 8'($random(seed) & 32'h7F);
    cb_in = 8'h20 + 8'($random(seed) & 32'h7F);
    cr_in = 8'h20 + 8'($random(seed) & 32'h7F);
    rgb_in = 24'($random(seed));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_CLAMP, CLAMP_RESET);
    rd(4'h2, 16'h0000);
    wr(ADDR_STATUS, 16'hFFFF);
    rd(ADDR_STATUS, {8'h00, 2'b01, vblank_in, field_in, vbi_flags_in});
    wr(ADDR_CTRL, 16'h0000);
    en_mon = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      vbi_flags_in <= 4'($random(seed));
      line(i[1], i[0], i[0], 1'b1, 7000);
    end
    line(1'b0, 1'b0, 1'b0, 1'b0, 40000);
    wr(ADDR_CTRL, 16'h0020);
    vbi_flags_in <= 4'h5;
    line(1'b1, 1'b1, 1'b0, 1'b1, 7000);
    strap_en <= 1'b1;
    wr(ADDR_CTRL, 16'h0080);
    vsync_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(ADDR_STATUS, {8'h00, 2'b11, vblank_in, field_in, vbi_flags_in});
    vsync_in <= 1'b0;
    strap_en <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(ADDR_STATUS, {8'h00, 2'b01, vblank_in, field_in, vbi_flags_in});
    // Wide formats may put an all-ones byte on the low lane; stop the stream monitor
    en_mon = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      d = 16'({smp[i], i[1:0]}) | (i[0] ? 16'h0140 : 16'h0000);
      wr(ADDR_CTRL, d);
      rd(ADDR_CTRL, d);
    end
    repeat (2) @(posedge sys_clk);
    results;
  end
endmodule : video_decoder_output_timing_tb
`default_nettype wire
